// File: verilog/prif_regs.sv
`timescale 1ns/1ps
module prif_regs #(
  parameter int WIN_BITS = prif_pkg::WIN_BITS_PERIPH,
  parameter int CH_BITS  = 8
) (
  input  wire logic        MCLK,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [31:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        RX_BEAT,
  input  wire logic        TX_BEAT,
  input  wire logic        PERIPH_EVENT,
  output logic             RX_ACTIVE,
  output logic             TX_ACTIVE,
  output logic [31:0]      RX_ADDR,
  output logic [31:0]      TX_ADDR,
  output logic [7:0]       MODE_OUT,
  output logic             IRQ
);

  // Only the two window sizes and at most eight shadow bits can be served.
  if (WIN_BITS != prif_pkg::WIN_BITS_PERIPH && WIN_BITS != prif_pkg::WIN_BITS_IRQC) begin : g_bad_win
    $error("WIN_BITS must select a 16-Kbyte or 4-Kbyte window.");
  end
  if (CH_BITS < 1 || CH_BITS > 8) begin : g_bad_ch
    $error("CH_BITS must lie between 1 and 8.");
  end

  logic [7:0]           mode_r, mode_nxt;
  logic [CH_BITS-1:0]   chst_r, chst_nxt;
  logic [2:0]           stat_r, stat_nxt;
  logic [2:0]           mask_r, mask_nxt;
  logic [31:0]          rdata_r, rdata_nxt;
  logic                 ready_r, ready_nxt;
  logic                 err_r, err_nxt;
  logic                 irq_r, irq_nxt;
  logic [13:0]          off;
  logic                 wr, rd, hit;
  logic                 wr_ctrl, wr_mode, wr_ena, wr_dis;
  logic                 wr_ien, wr_idis;
  logic                 wr_rxptr, wr_rxcnt, wr_txptr, wr_txcnt;
  logic                 stat_clr, rx_start, tx_start;
  logic                 rx_done, tx_done;
  prif_pkg::prif_chan_t rx_chan, tx_chan;

  // The window drops the byte lane bits and everything above the window.
  always_comb begin
    off = '0;
    off[WIN_BITS-1:2] = PADDR[WIN_BITS-1:2];
  end

  // Every access completes as one full word in the access phase.
  assign wr = PSEL && PENABLE && PWRITE && !ready_r;
  assign rd = PSEL && PENABLE && !PWRITE && !ready_r;

  always_comb begin
    case (off)
      prif_pkg::OFF_CTRL, prif_pkg::OFF_MODE, prif_pkg::OFF_ENA, prif_pkg::OFF_DIS,
      prif_pkg::OFF_CHST, prif_pkg::OFF_STAT, prif_pkg::OFF_IEN, prif_pkg::OFF_IDIS,
      prif_pkg::OFF_IMASK, prif_pkg::OFF_RXPTR, prif_pkg::OFF_RXCNT, prif_pkg::OFF_TXPTR,
      prif_pkg::OFF_TXCNT: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // One write strobe per writable word, raised only in the first access cycle.
  always_comb begin
    wr_ctrl  = 1'b0;
    wr_mode  = 1'b0;
    wr_ena   = 1'b0;
    wr_dis   = 1'b0;
    wr_ien   = 1'b0;
    wr_idis  = 1'b0;
    wr_rxptr = 1'b0;
    wr_rxcnt = 1'b0;
    wr_txptr = 1'b0;
    wr_txcnt = 1'b0;
    if (wr) begin
      case (off)
        prif_pkg::OFF_CTRL:  wr_ctrl  = 1'b1;
        prif_pkg::OFF_MODE:  wr_mode  = 1'b1;
        prif_pkg::OFF_ENA:   wr_ena   = 1'b1;
        prif_pkg::OFF_DIS:   wr_dis   = 1'b1;
        prif_pkg::OFF_IEN:   wr_ien   = 1'b1;
        prif_pkg::OFF_IDIS:  wr_idis  = 1'b1;
        prif_pkg::OFF_RXPTR: wr_rxptr = 1'b1;
        prif_pkg::OFF_RXCNT: wr_rxcnt = 1'b1;
        prif_pkg::OFF_TXPTR: wr_txptr = 1'b1;
        prif_pkg::OFF_TXCNT: wr_txcnt = 1'b1;
        default: begin
          // Status, shadow status, mask and unmapped words ignore writes.
        end
      endcase
    end
  end

  // A written one fires its command and a written zero does nothing.
  assign stat_clr = wr_ctrl && PWDATA[prif_pkg::CTRL_RST_STAT];
  assign rx_start = wr_ctrl && PWDATA[prif_pkg::CTRL_RX_START];
  assign tx_start = wr_ctrl && PWDATA[prif_pkg::CTRL_TX_START];

  // The answer stands one cycle after the first access cycle.
  always_comb begin
    ready_nxt = PSEL && PENABLE && !ready_r;
    err_nxt   = PSEL && PENABLE && !ready_r && !hit;
    rdata_nxt = rdata_r;
    if (rd) begin
      rdata_nxt = 32'h0000_0000;
      case (off)
        prif_pkg::OFF_MODE:  rdata_nxt[7:0] = mode_r;
        prif_pkg::OFF_CHST:  rdata_nxt[CH_BITS-1:0] = chst_r;
        prif_pkg::OFF_STAT:  rdata_nxt[2:0] = stat_r;
        prif_pkg::OFF_IMASK: rdata_nxt[2:0] = mask_r;
        prif_pkg::OFF_RXPTR: rdata_nxt = rx_chan.ptr;
        prif_pkg::OFF_RXCNT: rdata_nxt[15:0] = rx_chan.cnt;
        prif_pkg::OFF_TXPTR: rdata_nxt = tx_chan.ptr;
        prif_pkg::OFF_TXCNT: rdata_nxt[15:0] = tx_chan.cnt;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      rdata_r <= 32'h0000_0000;
      ready_r <= 1'b0;
      err_r   <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      ready_r <= ready_nxt;
      err_r   <= err_nxt;
    end
  end

  always_comb begin
    mode_nxt = mode_r;
    if (wr_mode) begin
      mode_nxt = PWDATA[7:0];
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      mode_r <= prif_pkg::MODE_RST;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  always_comb begin
    chst_nxt = chst_r;
    if (wr_ena) begin
      chst_nxt = chst_r | PWDATA[CH_BITS-1:0];
    end
    if (wr_dis) begin
      chst_nxt = chst_r & ~PWDATA[CH_BITS-1:0];
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      chst_r <= CH_BITS'(prif_pkg::CHST_RST);
    end else begin
      chst_r <= chst_nxt;
    end
  end

  always_comb begin
    mask_nxt = mask_r;
    if (wr_ien) begin
      mask_nxt = mask_r | PWDATA[2:0];
    end
    if (wr_idis) begin
      mask_nxt = mask_r & ~PWDATA[2:0];
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      mask_r <= prif_pkg::MASK_RST;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  // Hardware events come after the clear, so a set in the same cycle wins.
  always_comb begin
    stat_nxt = stat_r;
    if (stat_clr) begin
      stat_nxt = prif_pkg::STAT_RST;
    end
    if (rx_done) begin
      stat_nxt[prif_pkg::ST_RXEND] = 1'b1;
    end
    if (tx_done) begin
      stat_nxt[prif_pkg::ST_TXEND] = 1'b1;
    end
    if (PERIPH_EVENT) begin
      stat_nxt[prif_pkg::ST_EVT] = 1'b1;
    end
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      stat_r <= prif_pkg::STAT_RST;
      irq_r  <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      irq_r  <= irq_nxt;
    end
  end

  // One channel serves the receive path and one the transmit path.
  prif_chan rx_i (
    .mclk   (MCLK),
    .rst    (RST),
    .ptr_we (wr_rxptr),
    .cnt_we (wr_rxcnt),
    .start  (rx_start),
    .wdata  (PWDATA),
    .beat   (RX_BEAT),
    .chan   (rx_chan),
    .done   (rx_done)
  );

  prif_chan tx_i (
    .mclk   (MCLK),
    .rst    (RST),
    .ptr_we (wr_txptr),
    .cnt_we (wr_txcnt),
    .start  (tx_start),
    .wdata  (PWDATA),
    .beat   (TX_BEAT),
    .chan   (tx_chan),
    .done   (tx_done)
  );

  assign PRDATA    = rdata_r;
  assign PREADY    = ready_r;
  assign PSLVERR   = err_r;
  assign RX_ACTIVE = rx_chan.busy;
  assign TX_ACTIVE = tx_chan.busy;
  assign RX_ADDR   = rx_chan.ptr;
  assign TX_ADDR   = tx_chan.ptr;
  assign MODE_OUT  = mode_r;
  assign IRQ       = irq_r;

endmodule : prif_regs

// One transfer channel: a pointer and a count stepped by the peripheral's beats.
module prif_chan (
  input  wire logic            mclk,
  input  wire logic            rst,
  input  wire logic            ptr_we,
  input  wire logic            cnt_we,
  input  wire logic            start,
  input  wire logic [31:0]     wdata,
  input  wire logic            beat,
  output prif_pkg::prif_chan_t chan,
  output logic                 done
);

  prif_pkg::prif_chan_t chan_r, chan_nxt;
  logic                 last;

  // The final beat is the one taken while a single unit remains.
  assign last = chan_r.busy && beat && chan_r.cnt == 16'h0001;

  always_comb begin
    chan_nxt = chan_r;
    if (chan_r.busy && beat) begin
      chan_nxt.ptr = chan_r.ptr + 32'h0000_0001;
      chan_nxt.cnt = chan_r.cnt - 16'h0001;
    end
    if (last) begin
      chan_nxt.busy = 1'b0;
    end
    if (ptr_we) begin
      chan_nxt.ptr = wdata;
    end
    if (cnt_we) begin
      chan_nxt.cnt = wdata[15:0];
    end
    if (start && chan_r.cnt != 16'h0000) begin
      chan_nxt.busy = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      chan_r <= '{ptr: prif_pkg::PTR_RST, cnt: prif_pkg::CNT_RST, busy: 1'b0};
    end else begin
      chan_r <= chan_nxt;
    end
  end

  assign chan = chan_r;
  assign done = last;

endmodule : prif_chan

// File: common/prif_pkg.sv
package prif_pkg;

  // Register byte offsets inside the 16-Kbyte peripheral window.
  localparam logic [13:0] OFF_CTRL   = 14'h0000;
  localparam logic [13:0] OFF_MODE   = 14'h0004;
  localparam logic [13:0] OFF_ENA    = 14'h0010;
  localparam logic [13:0] OFF_DIS    = 14'h0014;
  localparam logic [13:0] OFF_CHST   = 14'h0018;
  localparam logic [13:0] OFF_STAT   = 14'h001c;
  localparam logic [13:0] OFF_IEN    = 14'h0020;
  localparam logic [13:0] OFF_IDIS   = 14'h0024;
  localparam logic [13:0] OFF_IMASK  = 14'h0028;
  localparam logic [13:0] OFF_RXPTR  = 14'h0030;
  localparam logic [13:0] OFF_RXCNT  = 14'h0034;
  localparam logic [13:0] OFF_TXPTR  = 14'h0038;
  localparam logic [13:0] OFF_TXCNT  = 14'h003c;

  // Window sizes in address bits.
  localparam int WIN_BITS_PERIPH = 14;
  localparam int WIN_BITS_IRQC   = 12;

  // Control register command bits.
  localparam int CTRL_RST_STAT = 0;
  localparam int CTRL_RX_START = 1;
  localparam int CTRL_TX_START = 2;

  // Status register bit positions.
  localparam int ST_RXEND = 0;
  localparam int ST_TXEND = 1;
  localparam int ST_EVT   = 2;

  localparam logic [7:0]  MODE_RST  = 8'h00;
  localparam logic [7:0]  CHST_RST  = 8'h00;
  localparam logic [2:0]  STAT_RST  = 3'h0;
  localparam logic [2:0]  MASK_RST  = 3'h0;
  localparam logic [31:0] PTR_RST   = 32'h0000_0000;
  localparam logic [15:0] CNT_RST   = 16'h0000;

  // One transfer channel as seen by the register file.
  typedef struct packed {
    logic [31:0] ptr;
    logic [15:0] cnt;
    logic        busy;
  } prif_chan_t;

endpackage : prif_pkg

// File: sim/prif_chk.sv
`timescale 1ns/1ps
module prif_chk (
  input wire logic        MCLK,
  input wire logic        RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        RX_BEAT,
  input wire logic        TX_BEAT,
  input wire logic        RX_ACTIVE,
  input wire logic        TX_ACTIVE,
  input wire logic [31:0] RX_ADDR,
  input wire logic [31:0] TX_ADDR,
  input wire logic [7:0]  MODE_OUT
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  chk_ready_wait: assert property (PSEL && $rose(PENABLE) |-> !PREADY ##1 PREADY) else $error("late ready");
  chk_ready_once: assert property (PREADY |=> !PREADY) else $error("long ready");
  chk_unmapped_err: assert property (PSEL && $rose(PENABLE) && PADDR[13:2] == 12'h003 |=>
    PSLVERR && PRDATA == 32'h0) else $error("bad unmapped answer");
  chk_rx_step: assert property (RX_ACTIVE && RX_BEAT |=> RX_ADDR == $past(RX_ADDR) + 32'h1) else $error("rx step");
  chk_tx_step: assert property (TX_ACTIVE && TX_BEAT |=> TX_ADDR == $past(TX_ADDR) + 32'h1) else $error("tx step");
  chk_rx_hold: assert property (!PSEL && !RX_BEAT |=> $stable(RX_ADDR)) else $error("rx moved");
  chk_rx_idle: assert property (!PSEL && !RX_ACTIVE |=> !RX_ACTIVE) else $error("rx woke");
  chk_mode_hold: assert property (!PSEL |=> $stable(MODE_OUT)) else $error("mode moved");
  cover property (PREADY && PSLVERR);
  cover property ($fell(RX_ACTIVE));
  cover property (TX_ACTIVE && TX_BEAT);
endmodule : prif_chk

bind prif_regs prif_chk chk_i (.*);

// File: sim/prif_cpu.sv
`timescale 1ns/1ps
module prif_cpu (
  input  wire logic        MCLK,
  input  wire logic        PREADY,
  input  wire logic        PSLVERR,
  input  wire logic [31:0] PRDATA,
  output logic             PSEL,
  output logic             PENABLE,
  output logic             PWRITE,
  output logic [31:0]      PADDR,
  output logic [31:0]      PWDATA
);
  initial {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
  // One APB transfer, held until ready is seen, then one idle cycle.
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    PSEL    <= 1'b1;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do @(posedge MCLK); while (PREADY !== 1'b1);
    q = PRDATA;
    e = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge MCLK);
  endtask : xfer
endmodule : prif_cpu

// File: sim/prif_regs_tb.sv
`timescale 1ns/1ps
module prif_regs_tb;
  logic        MCLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, RX_BEAT, TX_BEAT, PERIPH_EVENT;
  logic        RX_ACTIVE, TX_ACTIVE, IRQ, e;
  logic [31:0] PADDR, PWDATA, PRDATA, RX_ADDR, TX_ADDR, q;
  logic [7:0]  MODE_OUT;
  int          miscompares, n_checks;
  prif_regs uut (.*);
  prif_cpu  cpu (.*);
  initial MCLK = 1'b0;
  always #2.5 MCLK = ~MCLK;
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic wr(input logic [13:0] o, input logic [31:0] d);
    cpu.xfer(1'b1, {18'h0, o}, d, q, e);
  endtask : wr
  task automatic rd(input logic [13:0] o, input logic [31:0] x, input string n);
    cpu.xfer(1'b0, {18'h0, o}, 32'h0, q, e);
    chk(n, x, q);
  endtask : rd
  task automatic close_out;
    if (miscompares == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out
  initial begin
    #20000;
    miscompares++;
    close_out;
  end
  initial begin
    {RST, RX_BEAT, TX_BEAT, PERIPH_EVENT} = 4'h8;
    repeat (10) @(posedge MCLK);
    RST <= 1'b0;
    @(posedge MCLK);
    rd(prif_pkg::OFF_MODE, 32'h0, "mode");
    chk("slverr", 32'h0, {31'h0, e});
    rd(prif_pkg::OFF_IMASK, 32'h0, "imask");
    cpu.xfer(1'b1, 32'h0000_4007, 32'h0000_00a5, q, e);
    rd(prif_pkg::OFF_MODE, 32'ha5, "mode");
    chk("mode_out", 32'ha5, {24'h0, MODE_OUT});
    wr(prif_pkg::OFF_STAT, 32'h7);
    rd(prif_pkg::OFF_STAT, 32'h0, "stat");
    wr(prif_pkg::OFF_ENA, 32'h5);
    wr(prif_pkg::OFF_DIS, 32'h1);
    rd(prif_pkg::OFF_CHST, 32'h4, "chst");
    rd(14'h000c, 32'h0, "unmapped");
    chk("slverr", 32'h1, {31'h0, e});
    wr(prif_pkg::OFF_IEN, 32'h3);
    wr(prif_pkg::OFF_IDIS, 32'h2);
    rd(prif_pkg::OFF_IMASK, 32'h1, "imask");
    wr(prif_pkg::OFF_RXPTR, 32'h100);
    wr(prif_pkg::OFF_RXCNT, 32'h2);
    wr(prif_pkg::OFF_CTRL, 32'h0);
    chk("rx_idle", 32'h0, {31'h0, RX_ACTIVE});
    wr(prif_pkg::OFF_CTRL, 32'h2);
    chk("rx_active", 32'h1, {31'h0, RX_ACTIVE});
    RX_BEAT <= 1'b1;
    repeat (2) @(posedge MCLK);
    RX_BEAT <= 1'b0;
    @(posedge MCLK);
    chk("rx_addr", 32'h102, RX_ADDR);
    chk("rx_done", 32'h0, {31'h0, RX_ACTIVE});
    chk("irq", 32'h1, {31'h0, IRQ});
    rd(prif_pkg::OFF_RXCNT, 32'h0, "rxcnt");
    wr(prif_pkg::OFF_IDIS, 32'h1);
    chk("irq", 32'h0, {31'h0, IRQ});
    wr(prif_pkg::OFF_TXPTR, 32'h200);
    wr(prif_pkg::OFF_TXCNT, 32'h1);
    wr(prif_pkg::OFF_CTRL, 32'h4);
    chk("tx_active", 32'h1, {31'h0, TX_ACTIVE});
    TX_BEAT <= 1'b1;
    @(posedge MCLK);
    TX_BEAT <= 1'b0;
    PERIPH_EVENT <= 1'b1;
    @(posedge MCLK);
    PERIPH_EVENT <= 1'b0;
    chk("tx_addr", 32'h201, TX_ADDR);
    chk("tx_done", 32'h0, {31'h0, TX_ACTIVE});
    @(posedge MCLK);
    rd(prif_pkg::OFF_STAT, 32'h7, "stat");
    wr(prif_pkg::OFF_CTRL, 32'h1);
    rd(prif_pkg::OFF_STAT, 32'h0, "stat");
    close_out;
  end
endmodule : prif_regs_tb
